/* hw/dac_channel_calibration_datapath.sv */
/*
 * Calibration datapath of a 32-channel converter: input, trim and group
 * offset registers, one shared multiply-add engine that fills the
 * calibrated A/B registers, output-bank select and simultaneous load.
 * Assumes writes arrive decoded from the serial port on sys_clk, and
 * that the load and clear pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ns
`include "cal_regs.svh"

module dac_channel_calibration_datapath #(
	parameter bit WIDE16 = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic wr_valid,
	input cal_pkg::reg_write_t wr_req,
	input wire logic load_outputs_n,
	input wire logic clear_outputs_n,
	output logic [`NUM_CHANNELS-1:0][15:0] dac_code_q,
	output logic [15:0] group0_offset_term_q,
	output logic [15:0] group123_offset_term_q,
	output cal_pkg::status_t status_q
);
	import cal_pkg::*;

	localparam logic [15:0] INPUT_RST = WIDE16 ? `RST_INPUT_16 : `RST_INPUT_14;
	localparam logic [15:0] GAIN_RST = WIDE16 ? `RST_GAIN_16 : `RST_GAIN_14;
	localparam logic [15:0] OFFSET_RST = WIDE16 ? `RST_OFFSET_16 : `RST_OFFSET_14;
	localparam logic [15:0] FULL_SCALE = WIDE16 ? `FULL_SCALE_16 : `FULL_SCALE_14;
	localparam logic [15:0] MID_SCALE = WIDE16 ? `MID_SCALE_16 : `MID_SCALE_14;
	localparam logic [15:0] OFS_TERM_RST = WIDE16 ? {`RST_OFS_CODE, 2'b00} : {2'b00, `RST_OFS_CODE};

	logic [2:0] ctrl_q;
	logic [13:0] group0_offset_code_q;
	logic [13:0] group123_offset_code_q;
	logic [`NUM_CHANNELS-1:0] sel_q;
	logic [`NUM_CHANNELS-1:0][15:0] cal_a_q;
	logic [`NUM_CHANNELS-1:0][15:0] cal_b_q;
	logic [`NUM_CHANNELS-1:0] pend_a_q;
	logic [`NUM_CHANNELS-1:0] pend_b_q;
	logic [`NUM_CHANNELS-1:0] set_a;
	logic [`NUM_CHANNELS-1:0] set_b;
	logic [`NUM_CHANNELS-1:0] clr_a;
	logic [`NUM_CHANNELS-1:0] clr_b;
	calc_state_t state_q;
	logic [4:0] work_chan_q;
	logic work_bank_q;
	logic [4:0] pick_chan;
	logic pick_bank;
	logic pick_valid;
	logic [15:0] wdata_masked;
	logic bank_bit;
	logic we_in_a;
	logic we_in_b;
	logic we_gain;
	logic we_offset;
	logic [15:0] in_a_rd;
	logic [15:0] in_b_rd;
	logic [15:0] gain_rd;
	logic [15:0] offset_rd;
	logic [15:0] in_sel;
	logic [16:0] gain_p1;
	logic [32:0] product;
	logic [16:0] scaled;
	logic signed [18:0] sum;
	logic [15:0] result_sat;
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	logic [1:0] pin_s3_q;
	logic load_n_f_q;
	logic clear_n_f_q;

	assign bank_bit = ctrl_q[`CTRL_BANK_BIT];
	assign wdata_masked = wr_req.data & FULL_SCALE;
	assign we_in_a = wr_valid && wr_req.cmd == CMD_DATA && !bank_bit;
	assign we_in_b = wr_valid && wr_req.cmd == CMD_DATA && bank_bit;
	assign we_gain = wr_valid && wr_req.cmd == CMD_GAIN;
	assign we_offset = wr_valid && wr_req.cmd == CMD_OFFSET;

	// per-channel input and trim words; calibrated and output words are
	// kept as flops below because every channel loads in one edge
	cal_store #(.RESET_VALUE(INPUT_RST)) u_input_a (
		.sys_clk(sys_clk), .rstn(rstn), .we(we_in_a), .waddr(wr_req.chan),
		.wdata(wdata_masked), .raddr(work_chan_q), .rdata_q(in_a_rd)
	);
	cal_store #(.RESET_VALUE(INPUT_RST)) u_input_b (
		.sys_clk(sys_clk), .rstn(rstn), .we(we_in_b), .waddr(wr_req.chan),
		.wdata(wdata_masked), .raddr(work_chan_q), .rdata_q(in_b_rd)
	);
	cal_store #(.RESET_VALUE(GAIN_RST)) u_gain_trim (
		.sys_clk(sys_clk), .rstn(rstn), .we(we_gain), .waddr(wr_req.chan),
		.wdata(wdata_masked), .raddr(work_chan_q), .rdata_q(gain_rd)
	);
	cal_store #(.RESET_VALUE(OFFSET_RST)) u_offset_trim (
		.sys_clk(sys_clk), .rstn(rstn), .we(we_offset), .waddr(wr_req.chan),
		.wdata(wdata_masked), .raddr(work_chan_q), .rdata_q(offset_rd)
	);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `RST_CONTROL;
		end else if (wr_valid && wr_req.cmd == CMD_CONTROL) begin
			ctrl_q <= wr_req.data[2:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			group0_offset_code_q <= `RST_OFS_CODE;
			group123_offset_code_q <= `RST_OFS_CODE;
		end else if (wr_valid && wr_req.cmd == CMD_GROUP0_OFFSET_CODE) begin
			group0_offset_code_q <= wr_req.data[13:0];
		end else if (wr_valid && wr_req.cmd == CMD_GROUP123_OFFSET_CODE) begin
			group123_offset_code_q <= wr_req.data[13:0];
		end
	end

	// the term the output stage subtracts, already in channel code units
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			group0_offset_term_q <= OFS_TERM_RST;
			group123_offset_term_q <= OFS_TERM_RST;
		end else if (WIDE16) begin
			group0_offset_term_q <= {group0_offset_code_q, 2'b00};
			group123_offset_term_q <= {group123_offset_code_q, 2'b00};
		end else begin
			group0_offset_term_q <= {2'b00, group0_offset_code_q};
			group123_offset_term_q <= {2'b00, group123_offset_code_q};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= {4{`RST_SELECT}};
		end else if (wr_valid && wr_req.cmd == CMD_SELECT_ALL) begin
			sel_q <= {`NUM_CHANNELS{wr_req.data[0]}};
		end else if (wr_valid && wr_req.cmd == CMD_SELECT) begin
			sel_q[wr_req.chan[1:0]*`GROUP_SIZE +: `GROUP_SIZE] <= wr_req.data[7:0];
		end
	end

	// which bank a write makes stale; trims follow the global bank bit
	always_comb begin
		set_a = '0;
		set_b = '0;
		if (we_in_a || ((we_gain || we_offset) && !bank_bit)) begin
			set_a[wr_req.chan] = 1'b1;
		end
		if (we_in_b || ((we_gain || we_offset) && bank_bit)) begin
			set_b[wr_req.chan] = 1'b1;
		end
	end

	// lowest channel first, A before B within a channel
	always_comb begin
		pick_valid = 1'b0;
		pick_chan = 5'h00;
		pick_bank = 1'b0;
		for (int i = `NUM_CHANNELS - 1; i >= 0; i--) begin
			if (pend_a_q[i] || pend_b_q[i]) begin
				pick_valid = 1'b1;
				pick_chan = i[4:0];
				pick_bank = !pend_a_q[i];
			end
		end
	end

	always_comb begin
		clr_a = '0;
		clr_b = '0;
		if (state_q == ST_IDLE && pick_valid) begin
			if (pick_bank) begin
				clr_b[pick_chan] = 1'b1;
			end else begin
				clr_a[pick_chan] = 1'b1;
			end
		end
	end

	// a write landing as its entry is taken re-arms it, so the newer
	// value is recalculated after the one already under way
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_a_q <= '0;
			pend_b_q <= '0;
		end else begin
			pend_a_q <= (pend_a_q & ~clr_a) | set_a;
			pend_b_q <= (pend_b_q & ~clr_b) | set_b;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			work_chan_q <= 5'h00;
			work_bank_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (pick_valid) begin
						state_q <= ST_READ;
						work_chan_q <= pick_chan;
						work_bank_q <= pick_bank;
					end
				end
				ST_READ: begin
					state_q <= ST_CALC;
				end
				ST_CALC: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// the single multiply-add engine
	assign in_sel = work_bank_q ? in_b_rd : in_a_rd;
	assign gain_p1 = {1'b0, gain_rd} + 17'h00001;
	assign product = in_sel * gain_p1;
	assign scaled = WIDE16 ? product[32:16] : product[30:14];
	assign sum = $signed({2'b00, scaled}) + $signed({3'b000, offset_rd}) - $signed({3'b000, MID_SCALE});

	always_comb begin
		if (sum < 0) begin
			result_sat = 16'h0000;
		end else if (sum > $signed({3'b000, FULL_SCALE})) begin
			result_sat = FULL_SCALE;
		end else begin
			result_sat = sum[15:0];
		end
	end

	// only the engine writes here; there is no host path in or out
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cal_a_q <= {`NUM_CHANNELS{INPUT_RST}};
			cal_b_q <= {`NUM_CHANNELS{INPUT_RST}};
		end else if (state_q == ST_CALC) begin
			if (work_bank_q) begin
				cal_b_q[work_chan_q] <= result_sat;
			end else begin
				cal_a_q[work_chan_q] <= result_sat;
			end
		end
	end

	// pins: three flops, a change counts when stages two and three agree
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_q <= 2'b01;
			pin_s2_q <= 2'b01;
			pin_s3_q <= 2'b01;
		end else begin
			pin_s1_q <= {clear_outputs_n, load_outputs_n};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// clear starts asserted so outputs stay grounded until the pin is seen high
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			load_n_f_q <= 1'b1;
			clear_n_f_q <= 1'b0;
		end else begin
			if (pin_s2_q[0] == pin_s3_q[0]) begin
				load_n_f_q <= pin_s3_q[0];
			end
			if (pin_s2_q[1] == pin_s3_q[1]) begin
				clear_n_f_q <= pin_s3_q[1];
			end
		end
	end

	// load is level sensitive, so a tied-low load tracks every finished
	// recalculation; loads are ignored while clear holds the outputs
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dac_code_q <= {`NUM_CHANNELS{INPUT_RST}};
		end else if (!load_n_f_q && clear_n_f_q) begin
			for (int i = 0; i < `NUM_CHANNELS; i++) begin
				dac_code_q[i] <= sel_q[i] ? cal_b_q[i] : cal_a_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			status_q <= '{busy: 1'b0, outputs_grounded: 1'b1, thermal_en: 1'b0, power_down: 1'b0};
		end else begin
			status_q.busy <= (|pend_a_q) || (|pend_b_q) || state_q != ST_IDLE;
			status_q.outputs_grounded <= !clear_n_f_q;
			status_q.thermal_en <= ctrl_q[`CTRL_THERMAL_BIT];
			status_q.power_down <= ctrl_q[`CTRL_POWER_DOWN_BIT];
		end
	end

	property p_engine_sequence;
		@(posedge sys_clk) disable iff (!rstn)
		(state_q == ST_IDLE && pick_valid) |=> state_q == ST_READ ##1 state_q == ST_CALC ##1 state_q == ST_IDLE;
	endproperty
	a_engine_sequence: assert property (p_engine_sequence) else $error("engine did not run read, calc, idle");

	property p_bank_a_write;
		@(posedge sys_clk) disable iff (!rstn)
		(we_in_a && wr_req.chan == 5'h14) |=> pend_a_q[20] && !pend_b_q[20] ##[1:100] (state_q == ST_CALC && work_chan_q == 5'h14 && !work_bank_q);
	endproperty
	a_bank_a_write: assert property (p_bank_a_write) else $error("bank A write not recalculated");

	property p_trim_follows_bank;
		@(posedge sys_clk) disable iff (!rstn)
		(we_gain && bank_bit && wr_req.chan == 5'h07) |=> pend_b_q[7];
	endproperty
	a_trim_follows_bank: assert property (p_trim_follows_bank) else $error("trim write did not mark bank B");

	property p_cal_only_by_engine;
		@(posedge sys_clk) disable iff (!rstn)
		state_q != ST_CALC |=> $stable(cal_a_q) && $stable(cal_b_q);
	endproperty
	a_cal_only_by_engine: assert property (p_cal_only_by_engine) else $error("calibrated word changed outside calc");

	property p_saturate;
		@(posedge sys_clk) disable iff (!rstn)
		(state_q == ST_CALC && sum < 0) |-> result_sat == 16'h0000;
	endproperty
	a_saturate: assert property (p_saturate) else $error("negative code not clamped to zero");

	property p_select_all;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_valid && wr_req.cmd == CMD_SELECT_ALL) |=> sel_q == {`NUM_CHANNELS{$past(wr_req.data[0])}};
	endproperty
	a_select_all: assert property (p_select_all) else $error("global select did not set all bits");

	property p_load_takes_selected;
		@(posedge sys_clk) disable iff (!rstn)
		(!load_n_f_q && clear_n_f_q) |=> dac_code_q[9] == ($past(sel_q[9]) ? $past(cal_b_q[9]) : $past(cal_a_q[9]));
	endproperty
	a_load_takes_selected: assert property (p_load_takes_selected) else $error("output not loaded from selected bank");

	property p_clear_holds;
		@(posedge sys_clk) disable iff (!rstn)
		!clear_n_f_q |=> $stable(dac_code_q) && status_q.outputs_grounded;
	endproperty
	a_clear_holds: assert property (p_clear_holds) else $error("outputs moved or not grounded during clear");

	property p_control_bits;
		@(posedge sys_clk) disable iff (!rstn)
		(wr_valid && wr_req.cmd == CMD_CONTROL) |=> ##1 status_q.power_down == $past(wr_req.data[0], 2);
	endproperty
	a_control_bits: assert property (p_control_bits) else $error("power-down bit not reported");

endmodule

/* hw/cal_regs.svh */
/*
 * Constants of the calibration datapath: command codes, reset values,
 * control bit positions and arithmetic figures for both code widths.
 * Assumes it is included once by the package and by the design files.
 */
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH

`define NUM_CHANNELS 32
`define CHAN_W 5
`define GROUP_SIZE 8

`define CMD_DATA_CODE 4'h0
`define CMD_GAIN_CODE 4'h1
`define CMD_OFFSET_CODE 4'h2
`define CMD_GROUP0_OFFSET_CODE_CODE 4'h3
`define CMD_GROUP123_OFFSET_CODE_CODE 4'h4
`define CMD_CONTROL_CODE 4'h5
`define CMD_SELECT_CODE 4'h6
`define CMD_SELECT_ALL_CODE 4'h7

`define RST_INPUT_16 16'h5554
`define RST_GAIN_16 16'hFFFF
`define RST_OFFSET_16 16'h8000
`define RST_INPUT_14 16'h1555
`define RST_GAIN_14 16'h3FFF
`define RST_OFFSET_14 16'h2000
`define RST_OFS_CODE 14'h1555
`define RST_CONTROL 3'h0
`define RST_SELECT 8'h00

`define FULL_SCALE_16 16'hFFFF
`define FULL_SCALE_14 16'h3FFF
`define MID_SCALE_16 16'h8000
`define MID_SCALE_14 16'h2000

`define CTRL_BANK_BIT 2
`define CTRL_THERMAL_BIT 1
`define CTRL_POWER_DOWN_BIT 0

`define OFS_SCALE_SHIFT 2

`endif

/* hw/cal_pkg.sv */
/*
 * Types shared by the calibration datapath: write commands, the
 * recalculation state machine and the status word.
 * Assumes cal_regs.svh sits beside it.
 */
`include "cal_regs.svh"

package cal_pkg;

	typedef enum logic [3:0] {
		CMD_DATA = `CMD_DATA_CODE,
		CMD_GAIN = `CMD_GAIN_CODE,
		CMD_OFFSET = `CMD_OFFSET_CODE,
		CMD_GROUP0_OFFSET_CODE = `CMD_GROUP0_OFFSET_CODE_CODE,
		CMD_GROUP123_OFFSET_CODE = `CMD_GROUP123_OFFSET_CODE_CODE,
		CMD_CONTROL = `CMD_CONTROL_CODE,
		CMD_SELECT = `CMD_SELECT_CODE,
		CMD_SELECT_ALL = `CMD_SELECT_ALL_CODE
	} cmd_t;

	typedef struct packed {
		cmd_t cmd;
		logic [4:0] chan;
		logic [15:0] data;
	} reg_write_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_CALC = 3'b100
	} calc_state_t;

	typedef struct packed {
		logic busy;
		logic outputs_grounded;
		logic thermal_en;
		logic power_down;
	} status_t;

endpackage

/* hw/cal_store.sv */
/*
 * Per-channel word store: one write port, one read port whose data
 * come out of a register one cycle after the address.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`include "cal_regs.svh"

module cal_store #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [4:0] raddr,
	output logic [15:0] rdata_q
);

	logic [`NUM_CHANNELS-1:0][15:0] mem_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `NUM_CHANNELS; i++) begin
				mem_q[i] <= RESET_VALUE;
			end
		end else if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= mem_q[raddr];
		end
	end

endmodule

/* tb/cal_host.sv */
/*
 * Host model: issues register writes on the decoded write port, one
 * word per write, with a selectable idle gap after each one.
 * Assumes the caller waits until reset has been released.
 */
`timescale 1ns/1ns
module cal_host (
	input wire logic sys_clk,
	output logic wr_valid,
	output cal_pkg::reg_write_t wr_req
);
	import cal_pkg::*;

	initial begin
		wr_valid = 1'b0;
		wr_req = '0;
	end

	// the word bus shows inverted data when idle so a stale value is never mistaken for a write
	task automatic put(input cmd_t cmd, input logic [4:0] chan, input logic [15:0] data, input int gap);
		logic [15:0] d;
		d = data;
		if ((cmd == CMD_GROUP0_OFFSET_CODE || cmd == CMD_GROUP123_OFFSET_CODE) && d > 16'h2000) begin
			d = 16'h2000;
		end
		@(posedge sys_clk);
		#1;
		wr_req = '{cmd, chan, d};
		wr_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		wr_valid = 1'b0;
		wr_req = ~wr_req;
		repeat (gap) @(posedge sys_clk);
		#1;
	endtask
endmodule

/* tb/tb_dac_channel_calibration_datapath.sv */
/*
 * Self-checking bench: wide and narrow datapaths side by side, fed by
 * one host model; table of calibration cases, then bank, load and clear.
 * Assumes the design package and header are compiled first.
 */
`timescale 1ns/1ns
module tb_dac_channel_calibration_datapath;
	import cal_pkg::*;
	typedef struct {logic [4:0] ch; logic [15:0] d, m, c, q;} row_t;
	logic sys_clk, rstn, load_n, clear_n, wr_valid;
	reg_write_t wr_req;
	logic [31:0][15:0] code_w, code_n;
	logic [15:0] t0_w, t1_w, t0_n, t1_n;
	status_t st_w, st_n;
	int err_count, n_compared, cycles;
	row_t rows [5] = '{'{5'h00, 16'h1234, 16'hFFFF, 16'h8000, 16'h1234},
		'{5'h07, 16'h8000, 16'h7FFF, 16'h8000, 16'h4000},
		'{5'h08, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF},
		'{5'h1F, 16'h0010, 16'hFFFF, 16'h0000, 16'h0000},
		'{5'h14, 16'h1000, 16'hFFFF, 16'h8010, 16'h1010}};

	dac_channel_calibration_datapath #(.WIDE16(1'b1)) DUT (.sys_clk(sys_clk), .rstn(rstn), .wr_valid(wr_valid),
		.wr_req(wr_req), .load_outputs_n(load_n), .clear_outputs_n(clear_n), .dac_code_q(code_w),
		.group0_offset_term_q(t0_w), .group123_offset_term_q(t1_w), .status_q(st_w));
	dac_channel_calibration_datapath #(.WIDE16(1'b0)) DUT_N (.sys_clk(sys_clk), .rstn(rstn), .wr_valid(wr_valid),
		.wr_req(wr_req), .load_outputs_n(load_n), .clear_outputs_n(clear_n), .dac_code_q(code_n),
		.group0_offset_term_q(t0_n), .group123_offset_term_q(t1_n), .status_q(st_n));
	cal_host host (.sys_clk(sys_clk), .wr_valid(wr_valid), .wr_req(wr_req));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [15:0] exp_code(input bit wide, input logic [15:0] in, m, c);
		longint v;
		longint fs;
		if (!wide) begin
			in = in & 16'h3FFF;
			m = m & 16'h3FFF;
			c = c & 16'h3FFF;
		end
		fs = wide ? 65535 : 16383;
		v = ((longint'(in) * (longint'(m) + 1)) >> (wide ? 16 : 14)) + longint'(c) - (wide ? 32768 : 8192);
		if (v < 0) v = 0;
		if (v > fs) v = fs;
		return v[15:0];
	endfunction

	// busy lags the engine by a cycle, so give it two edges before polling
	task automatic idle();
		int n;
		n = 0;
		repeat (2) @(posedge sys_clk);
		while ((st_w.busy !== 1'b0 || st_n.busy !== 1'b0) && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		#1;
		check("busy", 16'h0000, {15'h0000, st_w.busy});
		check("busy_n", 16'h0000, {15'h0000, st_n.busy});
	endtask

	task automatic load_pulse();
		@(posedge sys_clk);
		#1;
		load_n = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		load_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	initial begin
		rstn = 1'b0;
		load_n = 1'b1;
		clear_n = 1'b1;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (8) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		check("grounded", 16'h0001, {15'h0000, st_w.outputs_grounded});
		for (int i = 0; i < 32; i++) begin
			check("code_w", 16'h5554, code_w[i]);
			check("code_n", 16'h1555, code_n[i]);
		end
		check("t0_w", 16'h5554, t0_w);
		check("t1_w", 16'h5554, t1_w);
		check("t0_n", 16'h1555, t0_n);
		check("t1_n", 16'h1555, t1_n);
		repeat (6) @(posedge sys_clk);
		#1;
		check("status", 16'h0000, {12'h000, st_w});
		foreach (rows[i]) begin
			host.put(CMD_GAIN, rows[i].ch, rows[i].m, 0);
			host.put(CMD_OFFSET, rows[i].ch, rows[i].c, 0);
			host.put(CMD_DATA, rows[i].ch, rows[i].d, 0);
		end
		idle();
		check("held", 16'h5554, code_w[0]);
		load_pulse();
		foreach (rows[i]) begin
			check("code_w", rows[i].q, code_w[rows[i].ch]);
			check("code_n", exp_code(0, rows[i].d, rows[i].m, rows[i].c), code_n[rows[i].ch]);
		end
		check("code_w9", 16'h5554, code_w[9]);
		check("code_n9", 16'h1555, code_n[9]);
		host.put(CMD_CONTROL, 5'h00, 16'h0007, 2);
		check("status", 16'h0003, {12'h000, st_w});
		check("status_n", 16'h0003, {12'h000, st_n});
		host.put(CMD_DATA, 5'h00, 16'h0ABC, 0);
		host.put(CMD_GAIN, 5'h07, 16'h7FFF, 0);
		idle();
		load_pulse();
		check("ch0", 16'h1234, code_w[0]);
		check("ch7", 16'h4000, code_w[7]);
		host.put(CMD_SELECT, 5'h00, 16'h0001, 0);
		load_pulse();
		check("ch0", 16'h0ABC, code_w[0]);
		check("ch7", 16'h4000, code_w[7]);
		host.put(CMD_SELECT_ALL, 5'h00, 16'h0001, 0);
		load_pulse();
		check("ch7", 16'h2AAA, code_w[7]);
		host.put(CMD_SELECT_ALL, 5'h00, 16'h0000, 0);
		load_pulse();
		check("ch0", 16'h1234, code_w[0]);
		check("ch7", 16'h4000, code_w[7]);
		host.put(CMD_CONTROL, 5'h00, 16'h0000, 0);
		@(posedge sys_clk);
		#1;
		load_n = 1'b0;
		host.put(CMD_DATA, 5'h14, 16'h2000, 0);
		idle();
		repeat (6) @(posedge sys_clk);
		#1;
		check("ch20", 16'h2010, code_w[20]);
		#1;
		clear_n = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		check("grounded", 16'h0001, {15'h0000, st_w.outputs_grounded});
		host.put(CMD_DATA, 5'h00, 16'h0100, 0);
		idle();
		repeat (6) @(posedge sys_clk);
		#1;
		check("ch0", 16'h1234, code_w[0]);
		#1;
		clear_n = 1'b1;
		repeat (8) @(posedge sys_clk);
		check("ch0", 16'h0100, code_w[0]);
		#1;
		load_n = 1'b1;
		host.put(CMD_GROUP0_OFFSET_CODE, 5'h00, 16'h0100, 0);
		host.put(CMD_GROUP123_OFFSET_CODE, 5'h00, 16'h2000, 2);
		check("t0_w", 16'h0400, t0_w);
		check("t1_w", 16'h8000, t1_w);
		check("t0_n", 16'h0100, t0_n);
		check("t1_n", 16'h2000, t1_n);
		#1;
		rstn = 1'b0;
		repeat (2) @(posedge sys_clk);
		check("code_w", 16'h5554, code_w[0]);
		check("t0_w", 16'h5554, t0_w);
		give_verdict();
	end
endmodule
